// ===== verilog/pwm_fault_trigger.v
// Fault latch and trigger compare part of a multi-generator PWM unit.
// Assumes AXI4-Lite master on aclk, fault inputs synchronous to aclk.
// Functional notes
// - Five fault inputs: two remappable, two general, one fixed safety input.
// - An enabled asserted fault forces the affected PWM outputs to safe state.
// - Safety fault input stays owned by the PWM unit throughout reset.
// - After reset the safety fault is enabled and in latched mode.
// - Fault mode field bits 1:0 is writable whatever the safety pin level.
// - Each generator holds a 16-bit writable trigger compare, reset zero.
// - Local time base matching trigger compare issues a converter trigger.
// - Each generator drives high and low outputs, both shut down on fault.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`include "pwm_fault_regs.vh"

module pwm_fault_trigger #(
    parameter NGEN = 3, // Number of PWM generators
    parameter CW = 16 // Counter and compare width
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire fault_in_a, // Remappable fault input
    input wire fault_in_b, // Remappable fault input
    input wire fault_in_c, // General fault input
    input wire fault_in_d, // General fault input
    input wire safety_fault_in, // Safety-class fault input, fixed pin
    output reg safety_pin_owned_r, // Pin held by the PWM unit, not remappable
    output reg [NGEN-1:0] pwm_high_out, // High-side outputs
    output reg [NGEN-1:0] pwm_low_out, // Low-side outputs
    output reg [NGEN-1:0] adc_trigger_r, // One-cycle converter triggers
    output reg [CW*NGEN-1:0] time_base_r, // Local time-base counts
    output reg irq_r // Interrupt, level
);

    localparam NF = `NUM_FAULTS;

    // Registers
    reg [1:0] fault_mode_sel_r;
    reg [NF-1:0] fault_en_r;
    reg [1:0] int_stat_r;
    reg [1:0] int_mask_r;
    reg pwm_en_r;
    reg [NGEN-1:0] local_tb_r;
    reg [CW-1:0] period_r;
    reg [CW*NGEN-1:0] trigger_compare_value_r;
    reg [CW*NGEN-1:0] duty_r;
    reg clear_pulse_r;
    reg [31:0] rdata_nxt;
    reg rresp_bad;
    reg wr_bad;
    reg [NGEN-1:0] trig_nxt;
    reg [CW*NGEN-1:0] tb_nxt;
    reg [NGEN-1:0] cyc_start;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg aw_have_r;
    reg w_have_r;
    wire [NF-1:0] fault_vec;
    wire [NF-1:0] fault_act;
    wire any_fault;
    integer g;
    integer k;

    // Index of a per-generator register, or all ones when out of range
    function [7:0] gen_index;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] d;
        begin
            d = addr - base;
            if (addr >= base && d[1:0] == 2'b00 && (d >> 2) < NGEN)
                gen_index = d >> 2;
            else
                gen_index = 8'hff;
        end
    endfunction

    // Byte-lane merge of write data into a counter-wide register
    function [CW-1:0] merge;
        input [CW-1:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < CW / 8; b = b + 1)
                if (strb[b])
                    merge[b*8 +: 8] = data[b*8 +: 8];
        end
    endfunction

    // Five independent fault inputs
    assign fault_vec = {safety_fault_in, fault_in_d, fault_in_c, fault_in_b, fault_in_a};

    // One channel per fault input
    genvar fi;
    generate
        for (fi = 0; fi < NF; fi = fi + 1)
        begin : g_fault
            fault_channel u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .fault_in(fault_vec[fi]),
                .enable(fault_en_r[fi]),
                .mode(fault_mode_sel_r),
                .clear(clear_pulse_r),
                .cycle_start(cyc_start[0]),
                .active_r(fault_act[fi])
            );
        end
    endgenerate

    assign any_fault = |fault_act;

    // Safety pin stays owned by this unit in and out of reset
    always @(posedge aclk)
    begin
        safety_pin_owned_r <= 1'b1;
    end

    // Time bases, trigger compare and next outputs
    always @*
    begin
        tb_nxt = time_base_r;
        trig_nxt = {NGEN{1'b0}};
        cyc_start = {NGEN{1'b0}};
        for (g = 0; g < NGEN; g = g + 1)
        begin
            if (!pwm_en_r)
                tb_nxt[g*CW +: CW] = {CW{1'b0}};
            else if (time_base_r[g*CW +: CW] >= period_r)
            begin
                tb_nxt[g*CW +: CW] = {CW{1'b0}};
                cyc_start[g] = 1'b1;
            end
            else
                tb_nxt[g*CW +: CW] = time_base_r[g*CW +: CW] + 1'b1;
            if (pwm_en_r && local_tb_r[g] &&
                time_base_r[g*CW +: CW] == trigger_compare_value_r[g*CW +: CW])
                trig_nxt[g] = 1'b1;
        end
    end

    // PWM outputs forced low on any active fault
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            time_base_r <= {CW*NGEN{1'b0}};
            adc_trigger_r <= {NGEN{1'b0}};
            pwm_high_out <= {NGEN{1'b0}};
            pwm_low_out <= {NGEN{1'b0}};
        end
        else
        begin
            time_base_r <= tb_nxt;
            adc_trigger_r <= trig_nxt;
            for (k = 0; k < NGEN; k = k + 1)
            begin
                if (any_fault || !pwm_en_r)
                begin
                    pwm_high_out[k] <= 1'b0;
                    pwm_low_out[k] <= 1'b0;
                end
                else
                begin
                    pwm_high_out[k] <= time_base_r[k*CW +: CW] < duty_r[k*CW +: CW];
                    pwm_low_out[k] <= !(time_base_r[k*CW +: CW] < duty_r[k*CW +: CW]);
                end
            end
        end
    end

    // Unmapped write address: error response and no effect
    always @*
    begin
        wr_bad = 1'b0;
        if ((aw_addr_r[1:0] != 2'b00 || aw_addr_r > `OFS_FAULT_CLR) &&
            aw_addr_r != `OFS_PERIOD &&
            gen_index(aw_addr_r, `OFS_TRIG_BASE) >= NGEN &&
            gen_index(aw_addr_r, `OFS_DUTY_BASE) >= NGEN)
            wr_bad = 1'b1;
    end

    // Write channel: take address and data in either order, respond after both
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            fault_mode_sel_r <= `MODE_LATCHED;
            fault_en_r <= {1'b1, {NF-1{1'b0}}};
            int_mask_r <= 2'b00;
            pwm_en_r <= 1'b0;
            local_tb_r <= {NGEN{1'b1}};
            period_r <= `PERIOD_RESET;
            trigger_compare_value_r <= {CW*NGEN{1'b0}};
            duty_r <= {CW*NGEN{1'b0}};
            clear_pulse_r <= 1'b0;
            int_stat_r <= 2'b00;
        end
        else
        begin
            clear_pulse_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Interrupt status set; set wins over a clear in the same cycle
            int_stat_r <= int_stat_r;
            if (aw_have_r && w_have_r && !s_axi_bvalid)
            begin
                case (aw_addr_r)
                `OFS_FAULT_CTRL:
                begin
                    if (w_strb_r[0])
                    begin
                        fault_mode_sel_r <= w_data_r[`FCTL_MODE_HI:`FCTL_MODE_LO];
                        fault_en_r[3:0] <= w_data_r[7:4];
                    end
                    if (w_strb_r[1])
                        fault_en_r[4] <= w_data_r[`FCTL_EN_HI];
                end
                `OFS_INT_STAT:
                    if (w_strb_r[0])
                        int_stat_r <= int_stat_r & ~w_data_r[1:0];
                `OFS_INT_MASK:
                    if (w_strb_r[0])
                        int_mask_r <= w_data_r[1:0];
                `OFS_PWM_CTRL:
                    if (w_strb_r[0])
                    begin
                        pwm_en_r <= w_data_r[0]; // Software clears faults first
                        local_tb_r <= w_data_r[NGEN:1];
                    end
                `OFS_FAULT_CLR:
                    if (w_strb_r[0])
                        clear_pulse_r <= w_data_r[0];
                `OFS_PERIOD:
                    period_r <= merge(period_r, w_data_r, w_strb_r);
                default:
                begin
                    if (gen_index(aw_addr_r, `OFS_TRIG_BASE) < NGEN)
                        trigger_compare_value_r[gen_index(aw_addr_r, `OFS_TRIG_BASE)*CW +: CW]
                            <= merge({CW{1'b0}}, w_data_r, w_strb_r);
                    else if (gen_index(aw_addr_r, `OFS_DUTY_BASE) < NGEN)
                        duty_r[gen_index(aw_addr_r, `OFS_DUTY_BASE)*CW +: CW]
                            <= merge({CW{1'b0}}, w_data_r, w_strb_r);
                end
                endcase
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_bad ? 2'b10 : 2'b00;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (any_fault)
                int_stat_r[`IRQ_FAULT] <= 1'b1;
            if (|trig_nxt)
                int_stat_r[`IRQ_TRIG] <= 1'b1;
        end
    end

    // Read mux
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        rresp_bad = 1'b0;
        case (s_axi_araddr)
        `OFS_FAULT_CTRL: rdata_nxt = {23'h0, fault_en_r[4], fault_en_r[3:0], 2'b00,
                                      fault_mode_sel_r};
        `OFS_FAULT_STAT: rdata_nxt = {26'h0, safety_fault_in, fault_act};
        `OFS_INT_STAT: rdata_nxt = {30'h0, int_stat_r};
        `OFS_INT_MASK: rdata_nxt = {30'h0, int_mask_r};
        `OFS_PWM_CTRL: rdata_nxt = {{(31-NGEN){1'b0}}, local_tb_r, pwm_en_r};
        `OFS_FAULT_CLR: rdata_nxt = 32'h0000_0000;
        `OFS_PERIOD: rdata_nxt = {16'h0000, period_r};
        default:
        begin
            if (gen_index(s_axi_araddr, `OFS_TRIG_BASE) < NGEN)
                rdata_nxt = {16'h0000, trigger_compare_value_r[
                    gen_index(s_axi_araddr, `OFS_TRIG_BASE)*CW +: CW]};
            else if (gen_index(s_axi_araddr, `OFS_DUTY_BASE) < NGEN)
                rdata_nxt = {16'h0000, duty_r[gen_index(s_axi_araddr, `OFS_DUTY_BASE)*CW +: CW]};
            else
                rresp_bad = 1'b1;
        end
        endcase
    end

    // Read channel: one cycle from address to data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_bad ? 2'b10 : 2'b00;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Interrupt output
    always @(posedge aclk)
    begin
        if (!aresetn)
            irq_r <= 1'b0;
        else
            irq_r <= |(int_stat_r & int_mask_r);
    end

endmodule // pwm_fault_trigger

// ===== verilog/pwm_fault_regs.vh
// Register offsets, field positions, reset values and mode codes for the PWM fault block.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef PWM_FAULT_REGS_VH
`define PWM_FAULT_REGS_VH

// Byte offsets
`define OFS_FAULT_CTRL 8'h00
`define OFS_FAULT_STAT 8'h04
`define OFS_INT_STAT 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_PWM_CTRL 8'h10
`define OFS_FAULT_CLR 8'h14
`define OFS_TRIG_BASE 8'h20
`define OFS_DUTY_BASE 8'h40
`define OFS_PERIOD 8'h60

// Fault control: mode field and enables
`define FCTL_MODE_LO 0
`define FCTL_MODE_HI 1
`define FCTL_EN_LO 4
`define FCTL_EN_HI 8
`define FCTL_RESET 32'h0000_0100

// Fault modes
`define MODE_LATCHED 2'b00
`define MODE_CYCLE 2'b01
`define MODE_OFF 2'b11

// Interrupt status bits
`define IRQ_FAULT 0
`define IRQ_TRIG 1

// Counts
`define NUM_FAULTS 5
`define SAFETY_IDX 4
`define PERIOD_RESET 16'hffff

`endif

// ===== verilog/fault_channel.v
// One fault input channel: enable, latched or cycle-by-cycle mode, software clear.
// Assumes the fault input is synchronous to aclk and active high.
`include "pwm_fault_regs.vh"

module fault_channel (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire fault_in, // Fault input level
    input wire enable, // Channel enabled
    input wire [1:0] mode, // Fault mode
    input wire clear, // Software clear pulse
    input wire cycle_start, // Start of PWM cycle
    output reg active_r // Fault shutdown active
);

    // Latched mode holds until input low and clear; cycle mode ends at cycle start
    always @(posedge aclk)
    begin
        if (!aresetn)
            active_r <= 1'b1; // Safe from power-up
        else if (!enable || mode == `MODE_OFF)
            active_r <= 1'b0;
        else if (fault_in)
            active_r <= 1'b1;
        else if (mode == `MODE_LATCHED)
        begin
            if (clear)
                active_r <= 1'b0;
        end
        else if (cycle_start)
            active_r <= 1'b0;
    end

endmodule // fault_channel

// ===== test/fault_source.sv
// Far-side model: external fault sources and the safety pin with its pull-down.
// Assumes the bench sets the requested levels right after a clock edge.
module fault_source (
    input wire aclk, // System clock
    input wire [4:0] level, // Requested fault levels, safety in bit 4
    input wire safety_drive, // Safety pin driven by the outside circuit
    input wire pulldown_en, // Internal pull-down on the safety pin
    output logic [3:0] general_out, // General fault lines a to d
    output logic safety_out // Safety fault pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_r = 1'b1;
    // General lines move on the clock, as the block expects synchronous faults
    always @(posedge aclk)
    begin
        float_r <= !float_r;
        general_out <= level[3:0];
    end
    // A released pin reads low only through the pull-down, otherwise it wanders
    assign safety_out = safety_drive ? level[4] : (pulldown_en ? 1'b0 : float_r);
endmodule // fault_source

// ===== test/pwm_fault_trigger_sva.sv
// Checker for the PWM fault and trigger block, watching its top ports only.
// Assumes one clock aclk and the synchronous active-low reset aresetn.
module pwm_fault_checker #(
    parameter NGEN = 3,
    parameter CW = 16
) (
    input wire aclk, // System clock
    input wire aresetn, // Reset, active low
    input wire s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire safety_pin_owned_r, // Safety pin ownership
    input wire [NGEN-1:0] pwm_high_out, // High-side outputs
    input wire [NGEN-1:0] pwm_low_out, // Low-side outputs
    input wire [NGEN-1:0] adc_trigger_r // Converter triggers
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic started_r = 1'b0;
    // Marks that the first edge has passed
    always @(posedge aclk) started_r <= 1'b1;
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    pin_owned_a: assert property (disable iff (1'b0) started_r |-> safety_pin_owned_r)
        else $error("safety pin released");
    sequence outs_low;
        pwm_high_out == '0 && pwm_low_out == '0;
    endsequence
    reset_safe_a: assert property ($rose(aresetn) |-> outs_low [*8])
        else $error("outputs not safe after reset");
    pair_excl_a: assert property ((pwm_high_out & pwm_low_out) == '0)
        else $error("high and low side both on");
    trig_pulse_a: assert property (adc_trigger_r[0] |=> !adc_trigger_r[0])
        else $error("trigger longer than one cycle");
    wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    busy_aw_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
endmodule // pwm_fault_checker

bind pwm_fault_trigger pwm_fault_checker #(.NGEN(NGEN), .CW(CW)) chk_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .safety_pin_owned_r(safety_pin_owned_r), .pwm_high_out(pwm_high_out),
    .pwm_low_out(pwm_low_out), .adc_trigger_r(adc_trigger_r));

// ===== test/pwm_fault_trigger_bench.sv
// Self-checking bench for the PWM fault and trigger block over AXI4-Lite.
// Assumes the register header is on the include path.
`include "pwm_fault_regs.vh"
module pwm_fault_trigger_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [4:0] level = 5'h10;
    logic safety_drive = 1'b1, pulldown_en = 1'b0, safety_pin, owned, irq_r, seen_trig, seen_on;
    logic [3:0] gen_f;
    logic [2:0] hi, lo, trig;
    logic [47:0] tb_count;
    logic [31:0] rd, mode_word;
    int n_errors = 0, total_checks = 0, cycles = 0;
    // Clock at 100 MHz
    initial forever #5 aclk = !aclk;
    fault_source fault_source_i (.aclk(aclk), .level(level), .safety_drive(safety_drive),
        .pulldown_en(pulldown_en), .general_out(gen_f), .safety_out(safety_pin));
    pwm_fault_trigger pwm_fault_trigger_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault_in_a(gen_f[0]),
        .fault_in_b(gen_f[1]), .fault_in_c(gen_f[2]), .fault_in_d(gen_f[3]),
        .safety_fault_in(safety_pin), .safety_pin_owned_r(owned), .pwm_high_out(hi),
        .pwm_low_out(lo), .adc_trigger_r(trig), .time_base_r(tb_count), .irq_r(irq_r));
    task give_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, resp);
        check({30'h0, resp}, 32'h0, "write response");
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, resp);
        check(rd, exp, "register read");
    endtask
    // Hang guard
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({31'h0, owned}, 32'h1, "pin ownership");
        expect_reg(`OFS_FAULT_CTRL, `FCTL_RESET);
        expect_reg(`OFS_FAULT_STAT, 32'h0000_0030);
        for (int g = 0; g < 3; g++)
        begin
            expect_reg(`OFS_TRIG_BASE + 8'(4 * g), 32'h0);
            wr(`OFS_TRIG_BASE + 8'(4 * g), 32'h0000_a5c0 + g);
            expect_reg(`OFS_TRIG_BASE + 8'(4 * g), 32'h0000_a5c0 + g);
        end
        for (int m = 0; m < 3; m++)
        begin
            mode_word = `FCTL_RESET | 32'(m == 0 ? `MODE_CYCLE : m == 1 ? `MODE_OFF : `MODE_LATCHED);
            wr(`OFS_FAULT_CTRL, mode_word);
            expect_reg(`OFS_FAULT_CTRL, mode_word);
        end
        wr(`OFS_FAULT_CLR, 32'h1);
        expect_reg(`OFS_FAULT_STAT, 32'h0000_0030);
        safety_drive <= 1'b0;
        pulldown_en <= 1'b1;
        repeat (3) @(posedge aclk);
        expect_reg(`OFS_FAULT_STAT, 32'h0000_0010);
        wr(`OFS_FAULT_CLR, 32'h1);
        expect_reg(`OFS_FAULT_STAT, 32'h0);
        wr(`OFS_PERIOD, 32'h9);
        for (int g = 0; g < 3; g++)
        begin
            wr(`OFS_DUTY_BASE + 8'(4 * g), 32'h4);
            wr(`OFS_TRIG_BASE + 8'(4 * g), 32'h5);
        end
        wr(`OFS_PWM_CTRL, 32'hf);
        seen_trig = 1'b0;
        seen_on = 1'b0;
        repeat (40)
        begin
            @(posedge aclk);
            seen_trig = seen_trig | (trig === 3'h7);
            seen_on = seen_on | (hi[0] === 1'b1);
        end
        check({30'h0, seen_trig, seen_on}, 32'h3, "trigger and drive seen");
        check({31'h0, tb_count[15:0] <= 16'h9}, 32'h1, "time base within period");
        wr(`OFS_PWM_CTRL, 32'h1);
        seen_trig = 1'b0;
        repeat (20)
        begin
            @(posedge aclk);
            seen_trig = seen_trig | (trig !== 3'h0);
        end
        check({31'h0, seen_trig}, 32'h0, "trigger without local time base");
        wr(`OFS_PWM_CTRL, 32'hf);
        for (int i = 0; i < 4; i++)
        begin
            wr(`OFS_FAULT_CTRL, `FCTL_RESET | (32'h10 << i));
            level[i] <= 1'b1;
            repeat (4) @(posedge aclk);
            check({26'h0, hi, lo}, 32'h0, "outputs in fault");
            level[i] <= 1'b0;
            repeat (3) @(posedge aclk);
            expect_reg(`OFS_FAULT_STAT, 32'h1 << i);
            wr(`OFS_FAULT_CLR, 32'h1);
            expect_reg(`OFS_FAULT_STAT, 32'h0);
        end
        wr(`OFS_INT_MASK, 32'h1 << `IRQ_FAULT);
        repeat (2) @(posedge aclk);
        check({31'h0, irq_r}, 32'h1, "fault interrupt");
        wr(`OFS_INT_STAT, 32'h1 << `IRQ_FAULT);
        repeat (2) @(posedge aclk);
        check({31'h0, irq_r}, 32'h0, "interrupt cleared");
        wr(`OFS_INT_MASK, 32'h1 << `IRQ_TRIG);
        repeat (12) @(posedge aclk);
        check({31'h0, irq_r}, 32'h1, "trigger interrupt");
        wr(`OFS_INT_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        check({31'h0, irq_r}, 32'h0, "interrupt masked");
        axi_read(8'hfc, rd, resp);
        check({30'h0, resp}, 32'h2, "unmapped read");
        axi_write(8'hfc, 32'h1, resp);
        check({30'h0, resp}, 32'h2, "unmapped write");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        expect_reg(`OFS_FAULT_CTRL, `FCTL_RESET);
        expect_reg(`OFS_FAULT_STAT, 32'h0000_0010);
        give_verdict();
    end
endmodule // pwm_fault_trigger_bench
